//--- pkg/reset_gen_pkg.sv
// Constants and types for the initial reset generator.
// Assumes a 10 MHz system clock and a separate oscillator-activity input.
package reset_gen_pkg;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 10000;
    // Reset pin hold time, microseconds
    localparam int unsigned PIN_HOLD_US = 5000;
    // Key combination hold time, milliseconds
    localparam int unsigned KEY_HOLD_MS = 4000;
    // Least times round up
    localparam int unsigned PIN_HOLD_CYC = (PIN_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned KEY_HOLD_CYC = KEY_HOLD_MS * CLK_KHZ;
    // Oscillator considered stopped after this many clocks without an edge
    localparam int unsigned OSC_LOSS_CYC = 1024;
    // Program start address after reset
    localparam logic [3:0] START_PAGE = 4'h1;
    localparam logic [7:0] START_STEP = 8'h00;

    // Key combination choices
    typedef enum logic [1:0] {
        KEY_OFF = 2'h0,
        KEY_01 = 2'h1,
        KEY_012 = 2'h2,
        KEY_0123 = 2'h3
    } key_sel_t;

    typedef struct packed {
        logic [3:0] page;
        logic [7:0] step;
    } start_addr_t;

    typedef struct packed {
        logic osc_ok;
        logic pin;
        logic key;
    } src_t;
endpackage : reset_gen_pkg

//--- src/initial_reset_generator.sv
// Initial reset generator: oscillator watchdog, filtered reset pin, key combo.
// Assumes osc_level toggles while the oscillator runs; inputs are synchronous.
// Functional notes
// (R1) Hold reset until oscillator runs; reassert on stop
// (R2) High reset pin starts initial reset
// (R3) Pin must stay high 5 ms first
// (R4) Release reset when pin returns low
// (R5) Selected key lines all high start reset
// (R6) Key combo must stay high 4 s
// (R7) Build option: off, keys 0-1, keys 0-2
// (R8) Board should reset by pin or keys
// (R9) Build option: all four keys together
// (R10) After reset fetch page 1 step 00H
// (R11) Application avoids selected keys together
// (R12) Reset output is OR of sources
// (R13) Filters count continuous highs, restart on drop
`timescale 1ns/100ps
module initial_reset_generator #(
    parameter reset_gen_pkg::key_sel_t KEY_SEL = reset_gen_pkg::KEY_OFF,
    parameter int unsigned PIN_CYC = reset_gen_pkg::PIN_HOLD_CYC,
    parameter int unsigned KEY_CYC = reset_gen_pkg::KEY_HOLD_CYC,
    parameter int unsigned LOSS_CYC = reset_gen_pkg::OSC_LOSS_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic osc_level,
    input wire logic reset_pin,
    input wire logic [3:0] key_input_lines,
    output logic cpu_reset,
    output reset_gen_pkg::src_t src_active,
    output reset_gen_pkg::start_addr_t start_addr
);
    localparam int CW = 32;

    // A count of one would pass a single-cycle glitch, so filters need two
    if (PIN_CYC < 2 || KEY_CYC < 2 || LOSS_CYC < 2) begin : g_bad_counts
        $error("initial_reset_generator: counts out of range");
    end

    typedef struct packed {
        logic osc_prev;
        logic [CW-1:0] loss_cnt;
        logic osc_ok;
        logic [CW-1:0] pin_cnt;
        logic pin_hit;
        logic [CW-1:0] key_cnt;
        logic key_hit;
        logic rst;
        logic [3:0] page;
        logic [7:0] step;
    } state_t;

    state_t q, d;

    function automatic logic key_combo(input reset_gen_pkg::key_sel_t s, input logic [3:0] k);
        unique case (s)
            reset_gen_pkg::KEY_OFF: key_combo = 1'b0; // see (R7)
            reset_gen_pkg::KEY_01: key_combo = &k[1:0]; // see (R7)
            reset_gen_pkg::KEY_012: key_combo = &k[2:0]; // see (R7)
            reset_gen_pkg::KEY_0123: key_combo = &k; // see (R9)
        endcase
    endfunction : key_combo

    logic keys_high;
    assign keys_high = key_combo(KEY_SEL, key_input_lines); // see (R5)

    always_comb begin
        d = q;
        d.osc_prev = osc_level;
        // Oscillator watchdog: any edge restarts loss timer
        if (osc_level != q.osc_prev) begin
            d.loss_cnt = '0;
            d.osc_ok = 1'b1; // see (R1)
        end else if (q.loss_cnt >= CW'(LOSS_CYC - 1)) begin
            d.osc_ok = 1'b0; // see (R1)
        end else begin
            d.loss_cnt = q.loss_cnt + CW'(1);
        end
        // Pin filter; held accepted until pin drops
        if (!reset_pin) begin
            d.pin_cnt = '0; // see (R13)
            d.pin_hit = 1'b0; // see (R4)
        end else if (q.pin_cnt >= CW'(PIN_CYC - 1)) begin
            d.pin_hit = 1'b1; // see (R2) see (R3)
        end else begin
            d.pin_cnt = q.pin_cnt + CW'(1);
        end
        if (!keys_high) begin
            d.key_cnt = '0; // see (R13)
            d.key_hit = 1'b0;
        end else if (q.key_cnt >= CW'(KEY_CYC - 1)) begin
            d.key_hit = 1'b1; // see (R6)
        end else begin
            d.key_cnt = q.key_cnt + CW'(1);
        end
        d.rst = !d.osc_ok || d.pin_hit || d.key_hit; // see (R12)
        d.page = reset_gen_pkg::START_PAGE; // see (R10)
        d.step = reset_gen_pkg::START_STEP;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
            // Seed with the input so a level frozen high is not taken as an edge
            q.osc_prev <= osc_level;
            q.rst <= 1'b1;
            q.page <= reset_gen_pkg::START_PAGE;
            q.step <= reset_gen_pkg::START_STEP;
        end else begin
            q <= d;
        end
    end

    assign cpu_reset = q.rst;
    assign src_active = '{osc_ok: q.osc_ok, pin: q.pin_hit, key: q.key_hit};
    assign start_addr = '{page: q.page, step: q.step};

    property p_pin_accept;
        @(posedge clk) disable iff (!nrst)
        (q.pin_cnt == CW'(PIN_CYC - 1)) && reset_pin |=> cpu_reset && src_active.pin;
    endproperty
    a_pin_accept: assert property (p_pin_accept) else $error("pin reset not taken"); // see (R3)

    property p_pin_early;
        @(posedge clk) disable iff (!nrst)
        $rose(reset_pin) |=> !src_active.pin;
    endproperty
    a_pin_early: assert property (p_pin_early) else $error("pin reset too early"); // see (R3)

    property p_pin_release;
        @(posedge clk) disable iff (!nrst)
        !reset_pin |=> !src_active.pin;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin reset held"); // see (R4)

    property p_key_accept;
        @(posedge clk) disable iff (!nrst)
        (q.key_cnt == CW'(KEY_CYC - 1)) && keys_high |=> cpu_reset && src_active.key;
    endproperty
    a_key_accept: assert property (p_key_accept) else $error("key reset not taken"); // see (R6)

    property p_key_drop;
        @(posedge clk) disable iff (!nrst)
        !keys_high |=> !src_active.key && q.key_cnt == '0;
    endproperty
    a_key_drop: assert property (p_key_drop) else $error("key filter not cleared"); // see (R13)

    property p_osc_stop;
        @(posedge clk) disable iff (!nrst)
        (q.loss_cnt == CW'(LOSS_CYC - 1)) && $stable(osc_level) |=> cpu_reset;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("osc loss missed"); // see (R1)

    property p_or;
        @(posedge clk) disable iff (!nrst)
        cpu_reset == (!src_active.osc_ok || src_active.pin || src_active.key);
    endproperty
    a_or: assert property (p_or) else $error("reset not OR of sources"); // see (R12)

    property p_start;
        @(posedge clk) disable iff (!nrst)
        $fell(cpu_reset) |-> start_addr.page == 4'h1 && start_addr.step == 8'h00;
    endproperty
    a_start: assert property (p_start) else $error("bad start address"); // see (R10)

    // Any sampled change of the oscillator input marks it running
    property p_osc_start;
        @(posedge clk) disable iff (!nrst)
        (osc_level != q.osc_prev) |=> src_active.osc_ok;
    endproperty
    a_osc_start: assert property (p_osc_start) else $error("osc start missed"); // see (R1)

    sequence s_osc_running;
        (osc_level != q.osc_prev) ##1 (osc_level != q.osc_prev);
    endsequence

    property p_osc_running;
        @(posedge clk) disable iff (!nrst)
        s_osc_running |-> src_active.osc_ok;
    endproperty
    a_osc_running: assert property (p_osc_running) else $error("osc flag lost"); // see (R1)

    property p_pin_hold;
        @(posedge clk) disable iff (!nrst)
        src_active.pin && reset_pin |=> src_active.pin && cpu_reset;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin reset dropped"); // see (R2)

    property p_key_hold;
        @(posedge clk) disable iff (!nrst)
        src_active.key && keys_high |=> src_active.key && cpu_reset;
    endproperty
    a_key_hold: assert property (p_key_hold) else $error("key reset dropped"); // see (R5)

    property p_key_early;
        @(posedge clk) disable iff (!nrst)
        $rose(keys_high) |=> !src_active.key;
    endproperty
    a_key_early: assert property (p_key_early) else $error("key reset too early"); // see (R6)

    // A drop between two highs must start the count again from one
    sequence s_pin_restart;
        !reset_pin ##1 reset_pin;
    endsequence

    property p_pin_restart;
        @(posedge clk) disable iff (!nrst)
        s_pin_restart |=> q.pin_cnt == CW'(1) && !src_active.pin;
    endproperty
    a_pin_restart: assert property (p_pin_restart) else $error("pin restart"); // see (R13)

    sequence s_key_restart;
        !keys_high ##1 keys_high;
    endsequence

    property p_key_restart;
        @(posedge clk) disable iff (!nrst)
        s_key_restart |=> q.key_cnt == CW'(1) && !src_active.key;
    endproperty
    a_key_restart: assert property (p_key_restart) else $error("key restart"); // see (R13)

    // With the option off no key pattern may ever reset the chip
    property p_key_off;
        @(posedge clk) disable iff (!nrst)
        (KEY_SEL == reset_gen_pkg::KEY_OFF) |-> !src_active.key;
    endproperty
    a_key_off: assert property (p_key_off) else $error("disabled key reset"); // see (R7)
endmodule : initial_reset_generator

//--- verif/board_model.sv
// Board side: oscillator, reset switch and key lines.
// Assumes bench commands; outputs move 1 ns after clk rises.
`timescale 1ns/100ps
module board_model (
    input wire logic clk,
    input wire logic osc_en,
    input wire logic pin_req,
    input wire logic [3:0] key_req,
    output logic osc_level,
    output logic reset_pin,
    output logic [3:0] key_input_lines
);
    initial begin
        osc_level = 1'b0;
        reset_pin = 1'b0;
        key_input_lines = 4'h0;
    end
    // Stopped oscillator freezes its level
    always @(posedge clk) begin
        osc_level <= #1 osc_en ? ~osc_level : osc_level;
        reset_pin <= #1 pin_req;
        key_input_lines <= #1 key_req;
    end
endmodule : board_model

//--- verif/tb_top.sv
// Bench for the initial reset generator, short filter counts.
// Assumes board_model drives pins one cycle after each command.
`timescale 1ns/100ps
module tb_top;
    logic clk, nrst, osc_en, pin_req, osc_level, reset_pin, cpu_reset;
    logic [3:0] key_req, key_input_lines;
    reset_gen_pkg::src_t src_active;
    reset_gen_pkg::start_addr_t start_addr;
    int n_fail = 0;
    int n_checks = 0;
    board_model board_model_i (.clk(clk), .osc_en(osc_en), .pin_req(pin_req),
        .key_req(key_req), .osc_level(osc_level), .reset_pin(reset_pin),
        .key_input_lines(key_input_lines));
    initial_reset_generator #(.KEY_SEL(reset_gen_pkg::KEY_012), .PIN_CYC(8),
        .KEY_CYC(16), .LOSS_CYC(8)) initial_reset_generator_i (.clk(clk),
        .nrst(nrst), .osc_level(osc_level), .reset_pin(reset_pin),
        .key_input_lines(key_input_lines), .cpu_reset(cpu_reset),
        .src_active(src_active), .start_addr(start_addr));
    logic [3:0] sel_reset;
    // One copy per key option, all fed by the same board lines
    for (genvar g = 0; g < 4; g++) begin : g_mode
        initial_reset_generator #(.KEY_SEL(reset_gen_pkg::key_sel_t'(g)), .PIN_CYC(8),
            .KEY_CYC(16), .LOSS_CYC(8)) initial_reset_generator_i (.clk(clk),
            .nrst(nrst), .osc_level(osc_level), .reset_pin(reset_pin),
            .key_input_lines(key_input_lines), .cpu_reset(sel_reset[g]),
            .src_active(), .start_addr());
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    // Bounded wait for release of reset
    task automatic wait_low();
        int i;
        for (i = 0; i < 20 && cpu_reset !== 1'b0; i++) cyc(1);
        if (i == 20) begin
            n_fail++;
            $display("[FAIL] %0t reset never released", $time);
            end_of_test();
        end
    endtask : wait_low
    // Pin held from power-on, oscillator started late
    task automatic t_power_up();
        cyc(12);
        chk(cpu_reset, 1'b1, "held without oscillator");
        chk(src_active.pin, 1'b1, "pin at power-up");
        chk(start_addr === 12'h100, 1'b1, "start address");
        osc_en = 1'b1;
        cyc(4);
        chk(src_active.osc_ok, 1'b1, "osc flag");
        chk(cpu_reset, 1'b1, "pin no longer holds reset");
        pin_req = 1'b0;
        wait_low();
    endtask : t_power_up
    task automatic t_pin();
        pin_req = 1'b1;
        cyc(7);
        pin_req = 1'b0;
        cyc(4);
        chk(cpu_reset, 1'b0, "short pulse taken");
        pin_req = 1'b1;
        cyc(8);
        chk(src_active.pin, 1'b0, "pin taken early");
        cyc(1);
        chk(cpu_reset, 1'b1, "pin reset");
        chk(src_active.pin, 1'b1, "pin flag");
        cyc(3);
        chk(src_active.pin, 1'b1, "pin flag dropped");
        pin_req = 1'b0;
        cyc(2);
        chk(cpu_reset, 1'b0, "pin release");
        chk(src_active.pin, 1'b0, "pin flag held");
    endtask : t_pin
    task automatic t_keys();
        key_req = 4'hB;
        cyc(20);
        chk(cpu_reset, 1'b0, "unselected combo");
        chk(sel_reset === 4'h2, 1'b1, "keys 0 and 1 option");
        key_req = 4'h7;
        cyc(15);
        key_req = 4'h0;
        cyc(3);
        chk(cpu_reset, 1'b0, "short combo taken");
        chk(sel_reset === 4'h0, 1'b1, "options not released");
        key_req = 4'h7;
        cyc(16);
        chk(src_active.key, 1'b0, "key taken early");
        cyc(1);
        chk(cpu_reset, 1'b1, "key reset");
        chk(src_active.key, 1'b1, "key flag");
        chk(sel_reset === 4'h6, 1'b1, "three key options");
        key_req = 4'hF;
        cyc(18);
        chk(sel_reset === 4'hE, 1'b1, "four key option");
        key_req = 4'h0;
        cyc(3);
        chk(cpu_reset, 1'b0, "key release");
        chk(src_active.key, 1'b0, "key flag held");
        chk(sel_reset === 4'h0, 1'b1, "options held");
    endtask : t_keys
    task automatic t_osc_stop();
        osc_en = 1'b0;
        cyc(14);
        chk(cpu_reset, 1'b1, "stop not seen");
        chk(src_active.osc_ok, 1'b0, "osc flag stuck");
        chk(sel_reset === 4'hF, 1'b1, "stop not seen by options");
        osc_en = 1'b1;
        wait_low();
    endtask : t_osc_stop
    // Reset in mid-run with the pin held, oscillator running
    task automatic t_mid_reset();
        pin_req = 1'b1;
        cyc(12);
        nrst = 1'b0;
        cyc(2);
        chk(cpu_reset, 1'b1, "reset not held");
        chk(src_active === 3'h0, 1'b1, "sources not cleared");
        pin_req = 1'b0;
        nrst = 1'b1;
        wait_low();
        chk(src_active.osc_ok, 1'b1, "osc after reset");
    endtask : t_mid_reset
    initial begin
        {nrst, osc_en, key_req} = '0;
        pin_req = 1'b1;
        cyc(8);
        nrst = 1'b1;
        t_power_up();
        t_pin();
        t_keys();
        t_osc_stop();
        t_mid_reset();
        end_of_test();
    end
endmodule : tb_top
